/* verilog/pllcg_top.v */
// PLL clock generator: reference input, input divider, loop multiplier,
// selectable core clocks and power-down gating, with an APB register slave.
// Assumes the reference pin and oscillator are sampled on the system clock.
//
// Overview of operation
// - Reference from external clock or crystal
// - Input divider programmable from 1 to 32
// - Loop multiplier programmable from 33 to 128
// - Oscillator frequency equals reference times multiply over divide
// - DSP clock: oscillator half or reference direct
// - Controller clock: oscillator quarter or reference direct
// - Power-down bit 1 gates oscillator and PLL
`timescale 1ns/1ps
`include "pllcg_defines.vh"
module pllcg_top #(
  parameter LOCK_CYCLES = `PLLCG_LOCK_CYCLES
) (
  input wire CLK_SYS_IN, // System clock, 25 MHz
  input wire RST_B_IN, // Synchronous reset, active low
  input wire PSEL_IN, // APB select
  input wire PENABLE_IN, // APB enable
  input wire PWRITE_IN, // APB direction
  input wire [11:0] PADDR_IN, // APB byte address
  input wire [31:0] PWDATA_IN, // APB write data
  output wire PREADY_OUT, // APB ready
  output wire PSLVERR_OUT, // APB error, unmapped address
  output reg [31:0] PRDATA_OUT, // APB read data
  input wire REFERENCE_CLOCK_PIN_IN, // Reference pin level
  output wire CRYSTAL_DRIVE_PIN_OUT, // Crystal drive, inverted reference
  output wire CRYSTAL_DRIVE_PIN_OE_OUT, // Drive enable in crystal mode
  output reg OSC_CLK_OUT, // Modelled oscillator output
  output reg DSP_CLK_OUT, // Signal-processor clock
  output reg MCU_CLK_OUT, // Controller clock
  output reg PLL_LOCKED_OUT // PLL settled after config change
);
  // ***********************************
  // Registers
  // ***********************************
  reg [2:0] ctrl_q;
  reg [4:0] input_divide_factor_q; // Stores factor minus one
  reg [7:0] loop_multiply_factor_q;
  reg [7:0] power_control_register_q;
  reg ref_q;
  reg [5:0] in_cnt_q;
  reg ref_div_q;
  reg [16:0] phase_acc_q;
  reg [15:0] per_cnt_q;
  reg [15:0] period_q;
  reg [15:0] lock_cnt_q;
  reg [1:0] osc_div_q;
  reg dsp_sel_q;
  reg mcu_sel_q;
  wire pwr_down = power_control_register_q[`PLLCG_PWR_DOWN_BIT];
  wire xtal_mode = ctrl_q[`PLLCG_CTRL_XTAL_MODE];
  wire wr_en = PSEL_IN & PENABLE_IN & PWRITE_IN;
  wire dsp_src;
  wire mcu_src;
  wire dsp_next;
  wire mcu_next;
  wire addr_ok = (PADDR_IN == `PLLCG_OFF_CTRL) || (PADDR_IN == `PLLCG_OFF_DIV) ||
                 (PADDR_IN == `PLLCG_OFF_STAT) || (PADDR_IN == `PLLCG_OFF_PWR);
  assign PREADY_OUT = 1'b1;
  assign PSLVERR_OUT = PSEL_IN & PENABLE_IN & ~addr_ok;
  // Crystal driver stops in power-down
  assign CRYSTAL_DRIVE_PIN_OE_OUT = xtal_mode & ~pwr_down;
  assign CRYSTAL_DRIVE_PIN_OUT = ~ref_q & ~pwr_down;
  // ***********************************
  // Factor clamp function
  // ***********************************
  function [7:0] clamp8;
    input [7:0] v;
    input [7:0] lo;
    input [7:0] hi;
    begin
      clamp8 = (v < lo) ? lo : ((v > hi) ? hi : v);
    end
  endfunction
  // Source mux shared by current and pending selector settings
  function sel_src;
    input direct;
    input ref_lvl;
    input osc_lvl;
    begin
      sel_src = direct ? ref_lvl : osc_lvl;
    end
  endfunction
  // Out-of-range factors are clamped to the legal span
  wire [7:0] in_div_m1 = clamp8({2'h0, PWDATA_IN[5:0]}, {2'h0, `PLLCG_INDIV_MIN},
    {2'h0, `PLLCG_INDIV_MAX}) - 8'h01;
  // ***********************************
  // APB register access
  // ***********************************
  always @(posedge CLK_SYS_IN) begin
    if (!RST_B_IN) begin
      ctrl_q <= `PLLCG_CTRL_RST;
      input_divide_factor_q <= `PLLCG_INDIV_RST;
      loop_multiply_factor_q <= `PLLCG_LOOPMUL_RST;
      power_control_register_q <= 8'h00;
    end else if (wr_en) begin
      case (PADDR_IN)
        `PLLCG_OFF_CTRL: ctrl_q <= PWDATA_IN[2:0];
        `PLLCG_OFF_DIV: begin
          input_divide_factor_q <= in_div_m1[4:0];
          loop_multiply_factor_q <= clamp8(PWDATA_IN[15:8], `PLLCG_LOOPMUL_MIN,
            `PLLCG_LOOPMUL_MAX);
        end
        `PLLCG_OFF_PWR: power_control_register_q <= PWDATA_IN[7:0];
        default: ctrl_q <= ctrl_q;
      endcase
    end
  end
  always @(posedge CLK_SYS_IN) begin
    if (!RST_B_IN) begin
      PRDATA_OUT <= 32'h0000_0000;
    end else if (PSEL_IN & ~PENABLE_IN & ~PWRITE_IN) begin
      case (PADDR_IN)
        `PLLCG_OFF_CTRL: PRDATA_OUT <= {29'h0, ctrl_q};
        `PLLCG_OFF_DIV: PRDATA_OUT <= {16'h0, loop_multiply_factor_q, 2'h0,
          {1'b0, input_divide_factor_q} + 6'h01};
        `PLLCG_OFF_STAT: PRDATA_OUT <= {28'h0, mcu_sel_q, dsp_sel_q, ~pwr_down,
          PLL_LOCKED_OUT};
        `PLLCG_OFF_PWR: PRDATA_OUT <= {24'h0, power_control_register_q};
        default: PRDATA_OUT <= 32'h0000_0000;
      endcase
    end
  end
  // ***********************************
  // Input divider and loop model
  // ***********************************
  // Divided reference period is measured in system cycles; the accumulator
  // adds twice the multiplier each cycle, giving multiplier-many output
  // periods per divided reference period.
  // Limitation: output saturates at half the system clock rate.
  wire ref_rise = REFERENCE_CLOCK_PIN_IN & ~ref_q;
  wire [16:0] acc_sum = phase_acc_q + {8'h00, loop_multiply_factor_q, 1'b0};
  wire [16:0] acc_left = acc_sum - {1'b0, period_q};
  always @(posedge CLK_SYS_IN) begin
    if (!RST_B_IN || pwr_down) begin
      ref_q <= 1'b0;
      in_cnt_q <= 6'h00;
      ref_div_q <= 1'b0;
    end else begin
      ref_q <= REFERENCE_CLOCK_PIN_IN;
      ref_div_q <= 1'b0;
      if (ref_rise) begin
        if (in_cnt_q >= {1'b0, input_divide_factor_q}) begin
          in_cnt_q <= 6'h00;
          ref_div_q <= 1'b1;
        end else begin
          in_cnt_q <= in_cnt_q + 6'h01;
        end
      end
    end
  end
  always @(posedge CLK_SYS_IN) begin
    if (!RST_B_IN || pwr_down) begin
      per_cnt_q <= 16'h0000;
      period_q <= 16'h0000;
      phase_acc_q <= 17'h00000;
      OSC_CLK_OUT <= 1'b0;
    end else begin
      if (ref_div_q) begin
        per_cnt_q <= 16'h0001;
        period_q <= per_cnt_q;
      end else if (per_cnt_q != 16'hFFFF) begin
        per_cnt_q <= per_cnt_q + 16'h0001;
      end
      // No toggles until one full divided period has been measured
      if (period_q == 16'h0000) begin
        phase_acc_q <= 17'h00000;
      end else if (acc_sum >= {1'b0, period_q}) begin
        // Clamp keeps the accumulator bounded when saturated
        phase_acc_q <= (acc_left >= {1'b0, period_q}) ? 17'h00000 : acc_left;
        OSC_CLK_OUT <= ~OSC_CLK_OUT;
      end else begin
        phase_acc_q <= acc_sum;
      end
    end
  end
  always @(posedge CLK_SYS_IN) begin
    if (!RST_B_IN || pwr_down || wr_en) begin
      lock_cnt_q <= 16'h0000;
      PLL_LOCKED_OUT <= 1'b0;
    end else if (ref_div_q) begin
      if (lock_cnt_q >= LOCK_CYCLES - 16'h0001) begin
        PLL_LOCKED_OUT <= 1'b1;
      end else begin
        lock_cnt_q <= lock_cnt_q + 16'h0001;
      end
    end
  end
  // ***********************************
  // Output dividers and glitch-free selectors
  // ***********************************
  reg osc_d1_q;
  always @(posedge CLK_SYS_IN) begin
    if (!RST_B_IN) begin
      osc_d1_q <= 1'b0;
      osc_div_q <= 2'h0;
    end else begin
      osc_d1_q <= OSC_CLK_OUT;
      if (OSC_CLK_OUT & ~osc_d1_q) begin
        osc_div_q <= osc_div_q + 2'h1;
      end
    end
  end
  assign dsp_src = sel_src(dsp_sel_q, ref_q, osc_div_q[0]);
  assign mcu_src = sel_src(mcu_sel_q, ref_q, osc_div_q[1]);
  assign dsp_next = sel_src(ctrl_q[`PLLCG_CTRL_DSP_DIRECT], ref_q, osc_div_q[0]);
  assign mcu_next = sel_src(ctrl_q[`PLLCG_CTRL_MCU_DIRECT], ref_q, osc_div_q[1]);
  // Selector only moves while output, old and new source are all low,
  // so no runt pulse appears; a stopped source that rests high delays it.
  always @(posedge CLK_SYS_IN) begin
    if (!RST_B_IN) begin
      dsp_sel_q <= 1'b1;
      mcu_sel_q <= 1'b1;
      DSP_CLK_OUT <= 1'b0;
      MCU_CLK_OUT <= 1'b0;
    end else begin
      if (!DSP_CLK_OUT && !dsp_src && !dsp_next) begin
        dsp_sel_q <= ctrl_q[`PLLCG_CTRL_DSP_DIRECT];
      end
      if (!MCU_CLK_OUT && !mcu_src && !mcu_next) begin
        mcu_sel_q <= ctrl_q[`PLLCG_CTRL_MCU_DIRECT];
      end
      DSP_CLK_OUT <= dsp_src;
      MCU_CLK_OUT <= mcu_src;
    end
  end
endmodule

/* verilog/pllcg_defines.vh */
// Constants for the PLL clock generator: register offsets, fields, limits.
// Assumes inclusion by bare name from the design file.
`ifndef PLLCG_DEFINES_VH
`define PLLCG_DEFINES_VH
// ***********************************
// Register byte offsets
// ***********************************
`define PLLCG_OFF_CTRL 12'h000
`define PLLCG_OFF_DIV 12'h004
`define PLLCG_OFF_STAT 12'h008
`define PLLCG_OFF_PWR 12'h00C
// ***********************************
// Fields and reset values
// ***********************************
`define PLLCG_CTRL_DSP_DIRECT 0
`define PLLCG_CTRL_MCU_DIRECT 1
`define PLLCG_CTRL_XTAL_MODE 2
`define PLLCG_PWR_DOWN_BIT 1
`define PLLCG_INDIV_RST 5'h00
`define PLLCG_LOOPMUL_RST 8'h21
`define PLLCG_CTRL_RST 3'h3
`define PLLCG_INDIV_MIN 6'h01
`define PLLCG_INDIV_MAX 6'h20
`define PLLCG_LOOPMUL_MIN 8'h21
`define PLLCG_LOOPMUL_MAX 8'h80
`define PLLCG_LOCK_CYCLES 16'h0400
`define PLLCG_DSP_DIV 4'h2
`define PLLCG_MCU_DIV 4'h4
`endif

/* bench/pllcg_ref_source.sv */
// Reference source: square wave, half period counted in system cycles.
// Assumes the bench holds en low to stop it; it then rests low.
`timescale 1ns/1ps
module pllcg_ref_source (
  input wire clk, // System clock
  input wire en, // Run enable
  input wire [7:0] half, // Half period
  output reg ref_out // Reference level
);
  reg [7:0] cnt_q = 8'h00;
  initial ref_out = 1'h0;
  always @(posedge clk) begin
    cnt_q <= (cnt_q + 8'h01 >= half) ? 8'h00 : cnt_q + 8'h01;
    if (!en) ref_out <= 1'h0;
    else if (cnt_q + 8'h01 >= half) ref_out <= ~ref_out;
  end
endmodule

/* bench/pllcg_properties.sv */
// Port checker for the clock generator.
// Assumes a bind onto pllcg_top.
`timescale 1ns/1ps
module pllcg_properties (
  input wire CLK_SYS_IN, // Clock
  input wire RST_B_IN, // Reset
  input wire PSEL_IN, // Select
  input wire PENABLE_IN, // Enable
  input wire PWRITE_IN, // Write
  input wire [11:0] PADDR_IN, // Address
  input wire [31:0] PWDATA_IN, // Data
  input wire PREADY_OUT, // Ready
  input wire PSLVERR_OUT, // Error
  input wire CRYSTAL_DRIVE_PIN_OE_OUT, // Drive on
  input wire OSC_CLK_OUT, // Oscillator
  input wire DSP_CLK_OUT, // Core clock
  input wire MCU_CLK_OUT, // Controller clock
  input wire PLL_LOCKED_OUT // Lock
);
  wire acc = PSEL_IN && PENABLE_IN;
  reg pd_q = 1'h0;
  reg pd2_q = 1'h0;
  always @(posedge CLK_SYS_IN) begin
    pd2_q <= pd_q && RST_B_IN;
    if (!RST_B_IN) pd_q <= 1'h0;
    else if (acc && PWRITE_IN && PADDR_IN == 12'h00C) pd_q <= PWDATA_IN[1];
  end
  default clocking @(posedge CLK_SYS_IN); endclocking
  default disable iff (!RST_B_IN);
  a_ready_high: assert property (PREADY_OUT) else $error("ready low");
  a_error_unmapped: assert property (acc && PADDR_IN > 12'h00C |-> PSLVERR_OUT)
    else $error("no error on unmapped");
  a_error_mapped: assert property (acc && (PADDR_IN == 12'h000 || PADDR_IN == 12'h004
    || PADDR_IN == 12'h008 || PADDR_IN == 12'h00C) |-> !PSLVERR_OUT)
    else $error("error on mapped");
  a_reset_quiet: assert property ($rose(RST_B_IN) |-> !DSP_CLK_OUT && !MCU_CLK_OUT
    && !PLL_LOCKED_OUT && !CRYSTAL_DRIVE_PIN_OE_OUT) else $error("outputs after reset");
  a_dsp_pulse: assert property ($changed(DSP_CLK_OUT) |=> $stable(DSP_CLK_OUT))
    else $error("short core pulse");
  a_mcu_pulse: assert property ($changed(MCU_CLK_OUT) |=> $stable(MCU_CLK_OUT))
    else $error("short controller pulse");
  a_power_gated: assert property (pd_q && pd2_q |-> !CRYSTAL_DRIVE_PIN_OE_OUT
    && !OSC_CLK_OUT) else $error("running in power-down");
  a_lock_restart: assert property (acc && PWRITE_IN && PADDR_IN == 12'h004
    |-> ##2 !PLL_LOCKED_OUT) else $error("lock kept after divider write");
endmodule

/* bench/pllcg_bench.sv */
// Self-checking bench: APB master, reference source, toggle counters.
// Assumes a zero-wait slave; LOCK_CYCLES is cut to 4.
`timescale 1ns/1ps
module pllcg_bench;
  reg clk = 1'h0;
  reg rst_b = 1'h0;
  reg psel = 1'h0;
  reg pen = 1'h0;
  reg pwr = 1'h0;
  reg [11:0] paddr = 12'h000;
  reg [31:0] pwdata = 32'h0;
  reg ref_en = 1'h0;
  reg [7:0] half = 8'h08;
  wire ref_pin, pready, slverr, drv, oe, osc, dsp, mcu, lock;
  wire [31:0] prdata;
  integer n_errors = 0;
  integer tests_run = 0;
  integer seed = 12671;
  integer cyc = 0;
  integer k;
  integer c [0:3];
  reg [3:0] p, q;
  reg [31:0] rd;
  reg er;
  reg [5:0] in_div;
  reg [7:0] lp_mul;
  initial forever #20 clk = ~clk;
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      n_errors = n_errors + 1;
      end_sim;
    end
  end
  pllcg_ref_source i_ref (.clk(clk), .en(ref_en), .half(half), .ref_out(ref_pin));
  pllcg_top #(.LOCK_CYCLES(16'h0004)) i_dut (.CLK_SYS_IN(clk), .RST_B_IN(rst_b),
    .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwdata),
    .PREADY_OUT(pready), .PSLVERR_OUT(slverr), .PRDATA_OUT(prdata),
    .REFERENCE_CLOCK_PIN_IN(ref_pin), .CRYSTAL_DRIVE_PIN_OUT(drv),
    .CRYSTAL_DRIVE_PIN_OE_OUT(oe), .OSC_CLK_OUT(osc), .DSP_CLK_OUT(dsp),
    .MCU_CLK_OUT(mcu), .PLL_LOCKED_OUT(lock));
  task end_sim;
    begin
      if (n_errors == 0 && tests_run > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
    end
  endtask
  task check(input [31:0] seen, input [31:0] exp);
    begin
      tests_run = tests_run + 1;
      if (seen !== exp) begin
        n_errors = n_errors + 1;
        $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task apb(input w, input [11:0] a, input [31:0] d);
    begin
      psel <= 1'h1;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'h1;
      @(posedge clk);
      while (pready !== 1'h1) @(posedge clk);
      rd = prdata;
      er = slverr;
      psel <= 1'h0;
      pen <= 1'h0;
      @(posedge clk);
    end
  endtask
  // Toggles seen at falling edges: 3 osc, 2 core, 1 controller, 0 reference
  task count(input integer n);
    integer j;
    begin
      for (j = 0; j < 4; j = j + 1) c[j] = 0;
      p = {osc, dsp, mcu, ref_pin};
      repeat (n) begin
        @(negedge clk);
        q = {osc, dsp, mcu, ref_pin};
        for (j = 0; j < 4; j = j + 1) c[j] = c[j] + (q[j] ^ p[j]);
        p = q;
      end
      @(posedge clk);
    end
  endtask
  function near(input integer s, input integer e, input integer t);
    near = (s >= e - t) && (s <= e + t);
  endfunction
  function [31:0] div_word(input [5:0] i, input [7:0] m);
    div_word = {16'h0000, (m < 8'h21) ? 8'h21 : (m > 8'h80) ? 8'h80 : m, 2'h0,
      (i < 6'h01) ? 6'h01 : (i > 6'h20) ? 6'h20 : i};
  endfunction
  initial begin
    repeat (6) @(posedge clk);
    rst_b <= 1'h1;
    ref_en <= 1'h1;
    @(posedge clk);
    apb(1'h0, 12'h000, 32'h0);
    check(rd, 32'h3);
    apb(1'h0, 12'h004, 32'h0);
    check(rd, div_word(6'h01, 8'h21));
    apb(1'h1, 12'h014, 32'h0);
    apb(1'h0, 12'h010, 32'h0);
    check(er, 1'h1);
    check(rd, 32'h0);
    for (k = 0; k < 8; k = k + 1) begin
      in_div = (k == 0) ? 6'h00 : (k == 1) ? 6'h3F : $random(seed);
      lp_mul = (k == 0) ? 8'hFF : (k == 1) ? 8'h20 : $random(seed);
      apb(1'h1, 12'h004, {16'h0000, lp_mul, 2'h0, in_div});
      apb(1'h0, 12'h004, 32'h0);
      check(rd, div_word(in_div, lp_mul));
    end
    // Slow reference so the modelled output stays below half the clock
    half <= 8'h10;
    apb(1'h1, 12'h004, 32'h2104);
    apb(1'h1, 12'h000, 32'h0);
    count(800);
    apb(1'h0, 12'h008, 32'h0);
    check(rd[0], 1'h1);
    count(800);
    check(near(c[3], c[0] * 33 / 4, 12), 1'h1);
    check(near(c[2], c[3] / 2, 2), 1'h1);
    check(near(c[1], c[3] / 4, 2), 1'h1);
    half <= 8'h04 + {$random(seed)} % 8;
    apb(1'h1, 12'h000, 32'h3);
    count(400);
    check(near(c[2], c[0], 2), 1'h1);
    check(near(c[1], c[0], 2), 1'h1);
    apb(1'h1, 12'h000, 32'h4);
    count(4);
    check(oe, 1'h1);
    apb(1'h1, 12'h00C, 32'h2);
    count(8);
    count(200);
    check({c[3] == 0, oe, drv}, 3'h4);
    apb(1'h1, 12'h00C, 32'h0);
    end_sim;
  end
endmodule
bind pllcg_top pllcg_properties u_chk (.CLK_SYS_IN, .RST_B_IN, .PSEL_IN, .PENABLE_IN,
  .PWRITE_IN, .PADDR_IN, .PWDATA_IN, .PREADY_OUT, .PSLVERR_OUT, .CRYSTAL_DRIVE_PIN_OE_OUT,
  .OSC_CLK_OUT, .DSP_CLK_OUT, .MCU_CLK_OUT, .PLL_LOCKED_OUT);
